// *** design/cps_slider_core.sv ***
// Slider processing: pressure, touch decision, stuck timer, compensation,
// centre-of-gravity position and movement, with its register file.
// Assumes a same-clock register port (I2C slave outside) and one-cycle
// sample strobes from the sensing front end at the scan period.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - Touch needs 1 to 4 consecutive samples
// R2 - Release needs 1 to 4 consecutive samples
// R3 - Stuck timeout seconds forces compensation, release
// R4 - After forced release wait for real lift
// R5 - Hysteresis is register code times four
// R6 - Norm is high and low bytes joined
// R7 - Ticks above hold level suspend averaging
// R8 - Negative threshold is code times four
// R9 - Negative count limit, zero code reserved
// R10 - Flag move when step exceeds percent threshold
// R11 - Pressure sums excess ticks above thresholds
// R12 - Zero pressure means released
// R13 - Pressure above hysteresis means touched
// R14 - Position is scaled weighted over plain sum
// R15 - Position readable as high, low bytes
// R16 - Lone first sensor gives position zero
// R17 - Enough low samples start offset compensation
// R18 - Ceiling is scale times sensors minus one
// R19 - Released keeps last position, no divide
// R20 - Division truncates, stays within range
module cps_slider_core #(
  parameter int          N             = cps_pkg::N_SENSORS,
  parameter int          TW            = cps_pkg::TICK_W,
  parameter int unsigned SECOND_CYCLES = cps_pkg::SECOND_CYCLES
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic [cps_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic                       reg_wr_i,
  input  wire logic [cps_pkg::DATA_W-1:0] reg_wdata_i,
  output logic      [cps_pkg::DATA_W-1:0] reg_rdata_o,
  input  wire logic                       sample_valid_i,
  input  wire logic [N*TW-1:0]            ticks_i,
  input  wire logic [N*TW-1:0]            channel_touch_threshold_i,
  output logic                            touched_o,
  output logic                            move_high_o,
  output logic                            move_low_o,
  output logic                            avg_hold_o,
  output logic                            compensate_o,
  output logic      [cps_pkg::POS_W-1:0]  slider_position_o,
  output logic      [TW+$clog2(N)-1:0]    slider_touch_pressure_o
);
  import cps_pkg::*;

  localparam int IW   = $clog2(N);
  localparam int PW   = TW + IW;
  localparam int WSW  = PW + IW;
  localparam int SCW  = NORM_W - NORM_SHIFT;
  localparam int NUMW = SCW + WSW;
  localparam int SW   = $clog2(SECOND_CYCLES);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // Register file
  logic [7:0] debounce_cfg, stuck_timeout, hysteresis, norm_high, norm_low;
  logic [7:0] avg_hold_thr, neg_thr, neg_limit, move_thr;
  logic [7:0] next_debounce_cfg, next_stuck_timeout, next_hysteresis;
  logic [7:0] next_norm_high, next_norm_low, next_avg_hold_thr;
  logic [7:0] next_neg_thr, next_neg_limit, next_move_thr, next_rdata;
  logic [POS_W-1:0] position;

  // Write decode and registered read mux
  always_comb begin
    next_debounce_cfg  = debounce_cfg;
    next_stuck_timeout = stuck_timeout;
    next_hysteresis    = hysteresis;
    next_norm_high     = norm_high;
    next_norm_low      = norm_low;
    next_avg_hold_thr  = avg_hold_thr;
    next_neg_thr       = neg_thr;
    next_neg_limit     = neg_limit;
    next_move_thr      = move_thr;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_DEBOUNCE:  next_debounce_cfg  = reg_wdata_i & DEBOUNCE_MASK;
        OFS_STUCK:     next_stuck_timeout = reg_wdata_i;
        OFS_HYST:      next_hysteresis    = reg_wdata_i;
        OFS_NORM_HIGH: next_norm_high     = reg_wdata_i;
        OFS_NORM_LOW:  next_norm_low      = reg_wdata_i;
        OFS_AVG_HOLD:  next_avg_hold_thr  = reg_wdata_i;
        OFS_NEG_THR:   next_neg_thr       = reg_wdata_i;
        OFS_NEG_LIMIT: next_neg_limit     = reg_wdata_i;
        OFS_MOVE:      next_move_thr      = reg_wdata_i;
        default:       next_move_thr      = move_thr;
      endcase
    end
    case (reg_addr_i)
      OFS_DEBOUNCE:  next_rdata = debounce_cfg;
      OFS_STUCK:     next_rdata = stuck_timeout;
      OFS_HYST:      next_rdata = hysteresis;
      OFS_NORM_HIGH: next_rdata = norm_high;
      OFS_NORM_LOW:  next_rdata = norm_low;
      OFS_AVG_HOLD:  next_rdata = avg_hold_thr;
      OFS_NEG_THR:   next_rdata = neg_thr;
      OFS_NEG_LIMIT: next_rdata = neg_limit;
      OFS_MOVE:      next_rdata = move_thr;
      OFS_POS_HIGH:  next_rdata = position[POS_W-1:8]; // [R15]
      OFS_POS_LOW:   next_rdata = position[7:0];       // [R15]
      default:       next_rdata = 8'h00;
    endcase
  end

  // Register stage of the register file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debounce_cfg  <= RST_DEBOUNCE;
      stuck_timeout <= RST_STUCK;
      hysteresis    <= RST_HYST;
      norm_high     <= RST_NORM_HIGH;
      norm_low      <= RST_NORM_LOW;
      avg_hold_thr  <= RST_AVG_HOLD;
      neg_thr       <= RST_NEG_THR;
      neg_limit     <= RST_NEG_LIMIT;
      move_thr      <= RST_MOVE;
      reg_rdata_o   <= 8'h00;
    end else begin
      debounce_cfg  <= next_debounce_cfg;
      stuck_timeout <= next_stuck_timeout;
      hysteresis    <= next_hysteresis;
      norm_high     <= next_norm_high;
      norm_low      <= next_norm_low;
      avg_hold_thr  <= next_avg_hold_thr;
      neg_thr       <= next_neg_thr;
      neg_limit     <= next_neg_limit;
      move_thr      <= next_move_thr;
      reg_rdata_o   <= next_rdata;
    end
  end

  // ==========================================================================
  // Derived levels
  logic [NORM_W-1:0]    scale_norm;
  logic [SCW-1:0]       pos_scale;
  logic [POS_W-1:0]     pos_ceiling;
  logic [POS_W-1:0]     move_level;
  logic [9:0]           hyst_level, avg_level, neg_level;
  logic [DB_W-1:0]      touch_code, release_code;
  logic [7:0]           neg_limit_eff;

  assign scale_norm    = {norm_high, norm_low};                         // [R6]
  assign pos_scale     = scale_norm[NORM_W-1:NORM_SHIFT];               // [R14]
  assign pos_ceiling   = POS_W'(pos_scale * (N - 1));                   // [R18]
  assign move_level    = POS_W'((32'(move_thr) * 32'(pos_ceiling)) / PCT_FULL); // [R10]
  assign hyst_level    = {hysteresis, {TICK_SHIFT{1'b0}}};              // [R5]
  assign avg_level     = {avg_hold_thr, {TICK_SHIFT{1'b0}}};            // [R7]
  assign neg_level     = {neg_thr, {TICK_SHIFT{1'b0}}};                 // [R8]
  assign touch_code    = debounce_cfg[DB_TOUCH_LSB +: DB_W];
  assign release_code  = debounce_cfg[DB_RELEASE_LSB +: DB_W];
  assign neg_limit_eff = (neg_limit == 8'h00) ? 8'h01 : neg_limit;      // [R9]

  // ==========================================================================
  // Pressure, weighted sum and tick levels
  logic signed [TW:0]   tick_ext;
  logic signed [TW+1:0] diff_ext; // Room for a negative tick minus a large threshold
  logic [TW-1:0]      excess;
  logic [PW-1:0]      pressure;
  logic [WSW-1:0]     weighted;
  logic               any_above, any_below;

  always_comb begin
    tick_ext  = '0;
    diff_ext  = '0;
    excess    = '0;
    pressure  = '0;
    weighted  = '0;
    any_above = 1'b0;
    any_below = 1'b0;
    for (int i = 0; i < N; i++) begin
      tick_ext = $signed({ticks_i[i*TW+TW-1], ticks_i[i*TW +: TW]});
      diff_ext = (TW+2)'(tick_ext) - $signed({2'b00, channel_touch_threshold_i[i*TW +: TW]});
      excess   = diff_ext[TW+1] ? '0 : diff_ext[TW-1:0];                // [R11]
      pressure = pressure + PW'(excess);                                // [R11]
      weighted = weighted + WSW'(WSW'(excess) * WSW'(i));               // [R14] [R16]
      if (tick_ext > $signed((TW+1)'(avg_level))) begin
        any_above = 1'b1;                                               // [R7]
      end
      if (tick_ext < -$signed((TW+1)'(neg_level))) begin
        any_below = 1'b1;                                               // [R8]
      end
    end
  end

  // ==========================================================================
  // Position divider
  logic            div_start, div_busy, div_done;
  logic [NUMW-1:0] div_quot;

  // Divide only with nonzero pressure
  assign div_start = sample_valid_i && (pressure != '0) && !div_busy;    // [R19]

  cps_divider #(
    .NW (NUMW),
    .DW (PW)
  ) u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (div_start),
    .num_i   (NUMW'(NUMW'(pos_scale) * NUMW'(weighted))),               // [R14]
    .den_i   (pressure),
    .busy_o  (div_busy),
    .done_o  (div_done),
    .quot_o  (div_quot)
  );

  // ==========================================================================
  // Touch decision, stuck timer, compensation and movement
  cps_touch_state_t state, next_state;
  logic [1:0]       db_cnt, next_db_cnt;
  logic [SW-1:0]    sec_cnt, next_sec_cnt;
  logic [7:0]       secs, next_secs;
  logic [7:0]       neg_cnt, next_neg_cnt;
  logic             comp, next_comp, hold, next_hold;
  logic             mv_hi, next_mv_hi, mv_lo, next_mv_lo;
  logic             pos_valid, next_pos_valid;
  logic [POS_W-1:0] next_position, new_pos;
  logic [PW-1:0]    press_q, next_press_q;
  logic             raw_touch, raw_release, stuck_fire;

  assign raw_touch   = pressure > PW'(hyst_level);                      // [R13]
  assign raw_release = pressure == '0;                                  // [R12]
  assign new_pos     = div_quot[POS_W-1:0];                             // [R20]
  assign stuck_fire  = (state == TS_TOUCHED) && (stuck_timeout != 8'h00)
                       && (sec_cnt == SW'(SECOND_CYCLES - 1)) && (secs + 8'h01 == stuck_timeout);

  // Next values of the processing state
  always_comb begin
    next_state     = state;
    next_db_cnt    = db_cnt;
    next_sec_cnt   = '0;
    next_secs      = 8'h00;
    next_neg_cnt   = neg_cnt;
    next_comp      = 1'b0;
    next_hold      = hold;
    next_mv_hi     = mv_hi;
    next_mv_lo     = mv_lo;
    next_pos_valid = pos_valid;
    next_position  = position;
    next_press_q   = press_q;
    case (state)
      TS_RELEASED: begin
        if (sample_valid_i) begin
          if (raw_touch && db_cnt == touch_code) begin
            next_state  = TS_TOUCHED;                                   // [R1]
            next_db_cnt = 2'b00;
          end else if (raw_touch) begin
            next_db_cnt = db_cnt + 2'b01;                               // [R1]
          end else begin
            next_db_cnt = 2'b00;
          end
        end
      end
      TS_TOUCHED: begin
        if (stuck_timeout != 8'h00) begin
          next_secs    = secs;
          next_sec_cnt = sec_cnt + SW'(1);
          if (sec_cnt == SW'(SECOND_CYCLES - 1)) begin
            next_sec_cnt = '0;
            next_secs    = secs + 8'h01;
          end
        end
        if (stuck_fire) begin
          next_state  = TS_STUCK;                                       // [R3]
          next_comp   = 1'b1;                                           // [R3]
          next_db_cnt = 2'b00;
        end else if (sample_valid_i) begin
          if (raw_release && db_cnt == release_code) begin
            next_state  = TS_RELEASED;                                  // [R2]
            next_db_cnt = 2'b00;
          end else if (raw_release) begin
            next_db_cnt = db_cnt + 2'b01;                               // [R2]
          end else begin
            next_db_cnt = 2'b00;
          end
        end
      end
      TS_STUCK: begin
        if (sample_valid_i && raw_release) begin
          next_state = TS_RELEASED;                                     // [R4]
        end
      end
      default: next_state = TS_RELEASED;
    endcase
    if (sample_valid_i) begin
      next_hold    = any_above;                                         // [R7]
      next_press_q = pressure;
      next_neg_cnt = 8'h00;
      if (any_below && (neg_cnt + 8'h01 >= neg_limit_eff)) begin
        next_comp = 1'b1;                                               // [R17]
      end else if (any_below) begin
        next_neg_cnt = neg_cnt + 8'h01;                                 // [R17]
      end
    end
    if (state != TS_TOUCHED) begin
      next_mv_hi     = 1'b0;
      next_mv_lo     = 1'b0;
      next_pos_valid = 1'b0;
    end else if (div_done) begin
      next_position  = new_pos;                                         // [R14] [R19]
      next_pos_valid = 1'b1;
      next_mv_hi     = pos_valid && (new_pos > position) && (new_pos - position > move_level); // [R10]
      next_mv_lo     = pos_valid && (position > new_pos) && (position - new_pos > move_level); // [R10]
    end
  end

  // Register stage of the processing state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= TS_RELEASED;
      db_cnt    <= 2'b00;
      sec_cnt   <= '0;
      secs      <= 8'h00;
      neg_cnt   <= 8'h00;
      comp      <= 1'b0;
      hold      <= 1'b0;
      mv_hi     <= 1'b0;
      mv_lo     <= 1'b0;
      pos_valid <= 1'b0;
      position  <= '0;
      press_q   <= '0;
    end else begin
      state     <= next_state;
      db_cnt    <= next_db_cnt;
      sec_cnt   <= next_sec_cnt;
      secs      <= next_secs;
      neg_cnt   <= next_neg_cnt;
      comp      <= next_comp;
      hold      <= next_hold;
      mv_hi     <= next_mv_hi;
      mv_lo     <= next_mv_lo;
      pos_valid <= next_pos_valid;
      position  <= next_position;
      press_q   <= next_press_q;
    end
  end

  // Outputs
  assign touched_o               = (state == TS_TOUCHED);
  assign move_high_o             = mv_hi;
  assign move_low_o              = mv_lo;
  assign avg_hold_o              = hold;
  assign compensate_o            = comp;
  assign slider_position_o       = position;
  assign slider_touch_pressure_o = press_q;

  // ==========================================================================
  // Checks
  a_touch_direct: assert property (sample_valid_i && state == TS_RELEASED && touch_code == 2'b00
    && raw_touch |=> touched_o) // [R1]
    else $error("direct touch not taken on first sample");
  a_touch_wait: assert property (sample_valid_i && state == TS_RELEASED && touch_code != 2'b00
    && db_cnt == 2'b00 |=> !touched_o) // [R1]
    else $error("debounced touch taken too early");
  a_release_zero: assert property (sample_valid_i && state == TS_TOUCHED && release_code == 2'b00
    && raw_release && !stuck_fire |=> !touched_o) // [R2] [R12]
    else $error("zero pressure did not release");
  a_hyst_hold: assert property (sample_valid_i && state == TS_RELEASED
    && pressure <= PW'(hyst_level) |=> !touched_o) // [R13] [R5]
    else $error("touch without pressure above hysteresis");
  a_stuck_off: assert property (stuck_timeout == 8'h00 && state == TS_TOUCHED
    |=> state != TS_STUCK) // [R3]
    else $error("stuck release while timer disabled");
  a_stuck_lock: assert property (state == TS_STUCK && !(sample_valid_i && raw_release)
    |=> state == TS_STUCK && !touched_o) // [R4]
    else $error("touch reported before real lift");
  a_pos_hold: assert property (!(div_done && state == TS_TOUCHED) |=> $stable(position)) // [R19]
    else $error("position changed without a division");
  a_pos_range: assert property (div_done && state == TS_TOUCHED && !reg_wr_i
    |=> position <= $past(pos_ceiling)) // [R18] [R20]
    else $error("position above ceiling");
  a_avg_hold: assert property (sample_valid_i && any_above |=> avg_hold_o) // [R7]
    else $error("averaging not held above level");
  a_avg_free: assert property (sample_valid_i && !any_above |=> !avg_hold_o) // [R7]
    else $error("averaging held below level");
  a_neg_start: assert property (sample_valid_i && any_below && (neg_cnt + 8'h01 >= neg_limit_eff)
    |=> compensate_o && neg_cnt == 8'h00) // [R17] [R9]
    else $error("negative compensation not started");
  a_move_cause: assert property ($rose(move_high_o) || $rose(move_low_o) |-> $past(div_done)) // [R10]
    else $error("move flag without new position");

endmodule

`default_nettype wire

// *** design/cps_pkg.sv ***
// Constants, register map and state type of the capacitive slider processor.
// Assumes a register port driven by an I2C slave and a front end giving ticks.
package cps_pkg;

  // ==========================================================================
  // Register port
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0]  OFS_DEBOUNCE    = 8'h27;
  localparam logic [7:0]  OFS_STUCK       = 8'h28;
  localparam logic [7:0]  OFS_HYST        = 8'h29;
  localparam logic [7:0]  OFS_NORM_HIGH   = 8'h2b;
  localparam logic [7:0]  OFS_NORM_LOW    = 8'h2c;
  localparam logic [7:0]  OFS_AVG_HOLD    = 8'h2d;
  localparam logic [7:0]  OFS_NEG_THR     = 8'h2e;
  localparam logic [7:0]  OFS_NEG_LIMIT   = 8'h2f;
  localparam logic [7:0]  OFS_MOVE        = 8'h30;
  localparam logic [7:0]  OFS_POS_HIGH    = 8'h31;
  localparam logic [7:0]  OFS_POS_LOW     = 8'h32;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_DEBOUNCE    = 8'h01;
  localparam logic [7:0]  RST_STUCK       = 8'h00;
  localparam logic [7:0]  RST_HYST        = 8'h03;
  localparam logic [7:0]  RST_NORM_HIGH   = 8'h01;
  localparam logic [7:0]  RST_NORM_LOW    = 8'h80;
  localparam logic [7:0]  RST_AVG_HOLD    = 8'h50;
  localparam logic [7:0]  RST_NEG_THR     = 8'h50;
  localparam logic [7:0]  RST_NEG_LIMIT   = 8'h01;
  localparam logic [7:0]  RST_MOVE        = 8'h0a;

  // ==========================================================================
  // Field layout and scaling
  localparam logic [7:0]  DEBOUNCE_MASK   = 8'h0f;
  localparam int          DB_TOUCH_LSB    = 0;
  localparam int          DB_RELEASE_LSB  = 2;
  localparam int          DB_W            = 2;
  localparam int          TICK_SHIFT      = 2;
  localparam int          NORM_W          = 16;
  localparam int          NORM_SHIFT      = 5;
  localparam int          POS_W           = 16;
  localparam int          PCT_FULL        = 100;
  localparam int          N_SENSORS       = 6;
  localparam int          TICK_W          = 16;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned STUCK_UNIT_S    = 1;
  localparam int unsigned SECOND_CYCLES   = STUCK_UNIT_S * CLK_HZ;

  // ==========================================================================
  // Touch decision state
  typedef enum logic [1:0] {
    TS_RELEASED,
    TS_TOUCHED,
    TS_STUCK
  } cps_touch_state_t;

endpackage

// *** design/cps_divider.sv ***
// Sequential restoring divider, one quotient bit per clock.
// Assumes the caller never starts it with a zero divisor.
`timescale 1ns/1ps
`default_nettype none

module cps_divider #(
  parameter int NW = 36,
  parameter int DW = 19
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          start_i,
  input  wire logic [NW-1:0] num_i,
  input  wire logic [DW-1:0] den_i,
  output logic               busy_o,
  output logic               done_o,
  output logic [NW-1:0]      quot_o
);

  localparam int CW  = $clog2(NW);
  localparam int LAT = NW + 1; // NW steps, then done is registered

  logic          busy;
  logic          next_busy;
  logic          done;
  logic          next_done;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [DW-1:0] rem;
  logic [DW-1:0] next_rem;
  logic [NW-1:0] quo;
  logic [NW-1:0] next_quo;
  logic [DW-1:0] den;
  logic [DW-1:0] next_den;
  logic [DW:0]   shifted;
  logic [DW:0]   diff;

  // ==========================================================================
  // Shift-subtract step
  always_comb begin
    next_busy = busy;
    next_done = 1'b0;
    next_cnt  = cnt;
    next_rem  = rem;
    next_quo  = quo;
    next_den  = den;
    shifted   = {rem, quo[NW-1]};
    diff      = shifted - {1'b0, den};
    if (start_i && !busy) begin
      next_busy = 1'b1;
      next_cnt  = CW'(NW - 1);
      next_rem  = '0;
      next_quo  = num_i;
      next_den  = den_i;
    end else if (busy) begin
      if (!diff[DW]) begin
        next_rem = diff[DW-1:0];
        next_quo = {quo[NW-2:0], 1'b1};
      end else begin
        next_rem = shifted[DW-1:0];
        next_quo = {quo[NW-2:0], 1'b0};
      end
      next_cnt = cnt - 1'b1;
      if (cnt == '0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt  <= '0;
      rem  <= '0;
      quo  <= '0;
      den  <= '0;
    end else begin
      busy <= next_busy;
      done <= next_done;
      cnt  <= next_cnt;
      rem  <= next_rem;
      quo  <= next_quo;
      den  <= next_den;
    end
  end

  assign busy_o = busy;
  assign done_o = done;
  assign quot_o = quo;

  // ==========================================================================
  // Checks
  a_div_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy) |-> ##[LAT:LAT] done) // [R14]
    else $error("divider result not ready after fixed latency");

endmodule

`default_nettype wire

// *** tb/cps_host_model.sv ***
// Host side of the register port: writes and reads by address.
// Assumes the core's same-clock port, read data one cycle after address.
`timescale 1ns/1ps
`default_nettype none
module cps_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic      [7:0] wdata_o
);
  initial begin
    addr_o = 8'h00; wr_o = 1'b0; wdata_o = 8'h00;
  end
  // One-cycle write strobe with address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i); addr_o <= a; wr_o <= 1'b1; wdata_o <= d;
    @(posedge clk_i); wr_o <= 1'b0; wdata_o <= ~d;
  endtask
  // Address held, data taken after the registered mux settles
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i); addr_o <= a;
    @(posedge clk_i); @(posedge clk_i); #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_cap_slider_processor.sv ***
// Self-checking bench of the slider core: registers, touch, position.
// Assumes a scaled-down second count of 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_cap_slider_processor;
  import cps_pkg::*;
  logic clk_i = 0, rst_i = 1, sv = 0, tch, mh, ml, ah, cmp, seen = 0;
  logic [7:0] adr, wd, rdat, d;
  logic wr;
  logic [95:0] tk = '0;
  logic [15:0] pos;
  logic [18:0] prs;
  int failures = 0, n_compared = 0;
  localparam logic [7:0] AD[9] = '{OFS_DEBOUNCE, OFS_STUCK, OFS_HYST, OFS_NORM_HIGH, OFS_NORM_LOW,
                                   OFS_AVG_HOLD, OFS_NEG_THR, OFS_NEG_LIMIT, OFS_MOVE};
  localparam logic [7:0] RV[9] = '{8'h01, 8'h00, 8'h03, 8'h01, 8'h80, 8'h50, 8'h50, 8'h01, 8'h0a};
  initial forever #2.5 clk_i = ~clk_i;
  cps_host_model u_host (.clk_i(clk_i), .rdata_i(rdat), .addr_o(adr), .wr_o(wr), .wdata_o(wd));
  cps_slider_core #(.SECOND_CYCLES(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(adr),
    .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .sample_valid_i(sv), .ticks_i(tk),
    .channel_touch_threshold_i({6{16'h0014}}), .touched_o(tch), .move_high_o(mh), .move_low_o(ml),
    .avg_hold_o(ah), .compensate_o(cmp), .slider_position_o(pos), .slider_touch_pressure_o(prs));
  // Catch the one-cycle compensation pulse
  always @(posedge clk_i) seen <= sv ? 1'b0 : (seen | (cmp === 1'b1));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic smp(input logic [15:0] t0, input logic [15:0] t1);
    @(posedge clk_i); sv <= 1'b1; tk <= {64'h0, t1, t0};
    @(posedge clk_i); sv <= 1'b0;
    @(posedge clk_i); #1;
  endtask
  task automatic nap;
    repeat (40) @(posedge clk_i);
  endtask
  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values and an unmapped place
    for (int i = 0; i < 9; i++) begin
      u_host.rd(AD[i], d); chk(d, RV[i]);
    end
    u_host.rd(8'h2a, d); chk(d, 0);
    u_host.wr(OFS_DEBOUNCE, 8'hff); u_host.rd(OFS_DEBOUNCE, d); chk(d, 8'h0f);
    u_host.wr(OFS_DEBOUNCE, 8'h01);
    // Two-sample touch, shared press gives the midpoint
    smp(16'd120, 16'd120); chk(tch, 0); chk(prs, 200);
    smp(16'd120, 16'd120); chk(tch, 1); nap; chk(pos, 6);
    u_host.rd(OFS_POS_LOW, d); chk(d, 6); u_host.rd(OFS_POS_HIGH, d); chk(d, 0);
    // Steps of 6 equal the move level and do not flag, steps of 12 do
    smp(16'd0, 16'd120); nap; chk(pos, 12); chk(mh, 0); chk(ml, 0);
    smp(16'd120, 16'd0); nap; chk(pos, 0); chk(ml, 1); chk(mh, 0);
    smp(16'd0, 16'd120); nap; chk(mh, 1); chk(ml, 0);
    smp(16'd0, 16'd0); chk(tch, 0); chk(prs, 0); nap; chk(pos, 12); chk(mh, 0);
    // Pressure below a large hysteresis never touches
    u_host.wr(OFS_HYST, 8'hff);
    smp(16'd1000, 16'd0); chk(ah, 1); smp(16'd1000, 16'd0); chk(tch, 0);
    u_host.wr(OFS_HYST, 8'h03);
    // Negative ticks beyond the threshold request compensation
    smp(16'hfed4, 16'd0); chk(seen, 0); chk(ah, 0); smp(16'hfe70, 16'd0); chk(seen, 1);
    u_host.wr(OFS_NEG_LIMIT, 8'h02);
    smp(16'hfe70, 16'd0); chk(seen, 0); smp(16'hfe70, 16'd0); chk(seen, 1);
    // Direct touch, release after two zero samples
    u_host.wr(OFS_DEBOUNCE, 8'h04);
    smp(16'd120, 16'd120); chk(tch, 1); smp(16'd0, 16'd0); chk(tch, 1);
    smp(16'd0, 16'd0); chk(tch, 0);
    u_host.wr(OFS_DEBOUNCE, 8'h01);
    // Stuck timer forces release until a real lift
    u_host.wr(OFS_STUCK, 8'h01);
    smp(16'd120, 16'd120); smp(16'd120, 16'd120); chk(tch, 1);
    nap; chk(tch, 0); chk(seen, 1);
    smp(16'd120, 16'd120); smp(16'd120, 16'd120); chk(tch, 0);
    smp(16'd0, 16'd0); smp(16'd120, 16'd120); smp(16'd120, 16'd120); chk(tch, 1);
    wrap_up;
  end
endmodule
`default_nettype wire
